// [flash_erase_program_sequencer.sv]
// Host-side controller that drives the parallel flash pins through erase and program sequences.
module flash_erase_program_sequencer #(
  parameter logic [flash_seq_pkg::TIMER_W-1:0] SECTOR_LIMIT_CYC =
    flash_seq_pkg::TIMER_W'(flash_seq_pkg::SECTOR_ERASE_MAX_CYC),
  parameter logic [flash_seq_pkg::TIMER_W-1:0] CHIP_LIMIT_CYC =
    flash_seq_pkg::TIMER_W'(flash_seq_pkg::CHIP_ERASE_MAX_CYC)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // User request port
  input wire flash_seq_pkg::req_s req,
  input wire logic req_valid,
  output logic req_ready,
  // User status
  output logic busy,
  output logic done,
  output logic err,
  output logic [flash_seq_pkg::DATA_W-1:0] rd_data,
  // Flash pins
  output flash_seq_pkg::pins_s pins,
  input wire logic [flash_seq_pkg::DATA_W-1:0] dq_in
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ASSERT = 2'h1,
    ST_STROBE = 2'h3,
    ST_RELEASE = 2'h2
  } state_e;

  state_e state;
  flash_seq_pkg::op_e op;
  logic [flash_seq_pkg::ADDR_W-1:0] addr_q;
  logic [flash_seq_pkg::DATA_W-1:0] data_q;
  logic [2:0] step;
  logic [flash_seq_pkg::CNT_W-1:0] cnt;
  logic polling;
  logic have_first;
  logic last_alt;
  logic settled;
  logic abort_pending;
  logic [flash_seq_pkg::TIMER_W-1:0] timer;
  logic [flash_seq_pkg::TIMER_W-1:0] limit;
  logic [flash_seq_pkg::DATA_W-1:0] dq_meta;
  logic [flash_seq_pkg::DATA_W-1:0] dq_sync;
  flash_seq_pkg::step_s si;
  flash_seq_pkg::step_s si_new;
  flash_seq_pkg::step_s si_next;
  logic timed_out;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign si = flash_seq_pkg::step_info(op, step, addr_q, data_q);
  assign si_new = flash_seq_pkg::step_info(req.op, 3'h0, req.addr, req.data);
  assign si_next = flash_seq_pkg::step_info(op, step + 3'h1, addr_q, data_q);
  assign timed_out = (timer >= limit);

  always_comb begin
    unique case (op)
      flash_seq_pkg::OP_SECTOR_ERASE: limit = SECTOR_LIMIT_CYC;
      flash_seq_pkg::OP_CHIP_ERASE: limit = CHIP_LIMIT_CYC;
      default: limit = flash_seq_pkg::PROGRAM_MAX_CYC;
    endcase
  end

  // The data pins come from another chip, so they pass two flip-flops first.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  // The operation timer starts when the execute write has been latched.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer <= '0;
    end else if (!polling) begin
      timer <= '0;
    end else if (!timed_out) begin
      timer <= timer + 1'b1;
    end
  end

  // An abort asked for while the device works is held until the current poll read ends.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abort_pending <= 1'b0;
    end else if (state == ST_IDLE || !polling) begin
      abort_pending <= 1'b0;
    end else if (req_valid && req.op == flash_seq_pkg::OP_ABORT) begin
      abort_pending <= 1'b1;
    end
  end

  // Sequencer and pin drivers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      op <= flash_seq_pkg::OP_READ;
      addr_q <= '0;
      data_q <= '0;
      step <= 3'h0;
      cnt <= '0;
      polling <= 1'b0;
      have_first <= 1'b0;
      last_alt <= 1'b0;
      settled <= 1'b0;
      req_ready <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      rd_data <= 8'h00;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: 8'h00, dq_oe: 1'b0};
    end else begin
      done <= 1'b0;
      cnt <= cnt + 1'b1;
      unique case (state)
        ST_IDLE: begin
          if (req_valid) begin
            op <= req.op;
            addr_q <= req.addr;
            data_q <= req.data;
            step <= 3'h0;
            polling <= 1'b0;
            err <= 1'b0;
            req_ready <= 1'b0;
            busy <= 1'b1;
            cnt <= '0;
            state <= ST_ASSERT;
            pins.ce_n <= 1'b0;
            pins.addr <= si_new.addr;
            pins.dq_out <= si_new.data;
            pins.dq_oe <= !si_new.is_read;
          end
        end
        ST_ASSERT: begin
          if (cnt + 1'b1 >= flash_seq_pkg::SETUP_CYC) begin
            cnt <= '0;
            state <= ST_STROBE;
            if (si.is_read || polling) begin
              pins.oe_n <= 1'b0;
            end else begin
              pins.we_n <= 1'b0;
            end
          end
        end
        ST_STROBE: begin
          if (cnt + 1'b1 >= (pins.we_n ? flash_seq_pkg::RD_CYC : flash_seq_pkg::WE_CYC)) begin
            cnt <= '0;
            state <= ST_RELEASE;
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!pins.oe_n) begin
              rd_data <= dq_sync;
              have_first <= 1'b1;
              last_alt <= dq_sync[flash_seq_pkg::ALT_BIT];
              settled <= have_first && (dq_sync[flash_seq_pkg::ALT_BIT] == last_alt);
            end
          end
        end
        ST_RELEASE: begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 1'b0;
          if (cnt + 1'b1 >= flash_seq_pkg::RECOVER_CYC) begin
            cnt <= '0;
            state <= ST_ASSERT;
            pins.ce_n <= 1'b0;
            if (polling && abort_pending) begin
              op <= flash_seq_pkg::OP_ABORT;
              step <= 3'h0;
              polling <= 1'b0;
              pins.dq_out <= flash_seq_pkg::CMD_ABORT;
              pins.dq_oe <= 1'b1;
            end else if (polling && (settled || timed_out)) begin
              err <= !settled;
              polling <= 1'b0;
              done <= 1'b1;
              busy <= 1'b0;
              req_ready <= 1'b1;
              state <= ST_IDLE;
              pins.ce_n <= 1'b1;
            end else if (polling) begin
              pins.addr <= addr_q;
            end else if (!si.last) begin
              step <= step + 1'b1;
              pins.addr <= si_next.addr;
              pins.dq_out <= si_next.data;
              pins.dq_oe <= !si_next.is_read;
            end else if (op == flash_seq_pkg::OP_SECTOR_ERASE || op == flash_seq_pkg::OP_CHIP_ERASE
                         || op == flash_seq_pkg::OP_PROGRAM) begin
              polling <= 1'b1;
              have_first <= 1'b0;
              settled <= 1'b0;
              pins.addr <= addr_q;
            end else begin
              done <= 1'b1;
              busy <= 1'b0;
              req_ready <= 1'b1;
              state <= ST_IDLE;
              pins.ce_n <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  sequence s_sector_setup;
    $rose(pins.we_n) && pins.dq_out == flash_seq_pkg::CMD_SECTOR_SETUP
      && op == flash_seq_pkg::OP_SECTOR_ERASE;
  endsequence
  sequence s_sector_exec;
    $fell(pins.we_n) && pins.dq_out == flash_seq_pkg::CMD_SECTOR_EXEC;
  endsequence
  sequence s_program_setup;
    $rose(pins.we_n) && pins.dq_out == flash_seq_pkg::CMD_PROGRAM_SETUP
      && op == flash_seq_pkg::OP_PROGRAM && step == 3'h0;
  endsequence

  property p_we_under_ce;
    !pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe;
  endproperty
  a_we_under_ce: assert property (p_we_under_ce) else $error("write strobe without select");

  property p_we_width;
    $fell(pins.we_n) |-> (!pins.we_n && $stable(pins.addr) && $stable(pins.dq_out))[*4] ##1 pins.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width or data wrong");

  property p_data_hold;
    $rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out) && !pins.ce_n;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe rise");

  property p_oe_addr;
    $rose(pins.oe_n) |-> $stable(pins.addr) && !pins.ce_n && !pins.dq_oe;
  endproperty
  a_oe_addr: assert property (p_oe_addr) else $error("read address moved at strobe rise");

  property p_sector_pair;
    s_sector_setup |-> ##[1:20] s_sector_exec;
  endproperty
  a_sector_pair: assert property (p_sector_pair) else $error("sector setup not followed by execute");

  property p_program_pair;
    s_program_setup |-> ##[1:20] ($fell(pins.we_n) && pins.dq_out == data_q
      && pins.addr == addr_q);
  endproperty
  a_program_pair: assert property (p_program_pair) else $error("program write wrong");

  property p_timeout;
    polling && timed_out && state == ST_RELEASE && !settled && !abort_pending
      && cnt + 1'b1 >= flash_seq_pkg::RECOVER_CYC |-> ##1 (done && err && req_ready);
  endproperty
  a_timeout: assert property (p_timeout) else $error("operation limit not reported");

  property p_ready_busy;
    done |-> req_ready && !busy && pins.ce_n ##1 $stable(pins.ce_n) || state != ST_IDLE;
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("not ready after completion");

  property p_abort;
    $rose(abort_pending) |-> ##[1:40] ($fell(pins.we_n) && pins.dq_out == flash_seq_pkg::CMD_ABORT);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not written");

endmodule // flash_erase_program_sequencer

// [flash_seq_pkg.sv]
// Constants, types and helper functions for the parallel flash command sequencer.
package flash_seq_pkg;

  localparam int CLK_MHZ = 40;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int TIMER_W = 20;
  localparam int SYNC_STAGES = 2;

  // Bus timing, in ns as chosen for the slowest supported parts.
  localparam int T_SETUP_NS = 25;
  localparam int T_WE_NS = 100;
  localparam int T_READ_NS = 200;
  localparam int T_RECOVER_NS = 50;

  // Operation time limits.
  localparam int SECTOR_ERASE_MAX_MS = 4;
  localparam int CHIP_ERASE_MAX_MS = 20;
  localparam int PROGRAM_MAX_US = 100;

  // A least time rounds up to whole cycles and never falls below one.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(ns_to_cyc(T_SETUP_NS));
  localparam logic [CNT_W-1:0] WE_CYC = CNT_W'(ns_to_cyc(T_WE_NS));
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(ns_to_cyc(T_READ_NS) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(ns_to_cyc(T_RECOVER_NS));
  localparam int SECTOR_ERASE_MAX_CYC = SECTOR_ERASE_MAX_MS * CLK_MHZ * 1000;
  localparam int CHIP_ERASE_MAX_CYC = CHIP_ERASE_MAX_MS * CLK_MHZ * 1000;
  localparam logic [TIMER_W-1:0] PROGRAM_MAX_CYC = TIMER_W'(PROGRAM_MAX_US * CLK_MHZ);

  // Command codes written on the data pins.
  localparam logic [7:0] CMD_SECTOR_SETUP = 8'h20;
  localparam logic [7:0] CMD_SECTOR_EXEC = 8'hD0;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h10;
  localparam logic [7:0] CMD_ABORT = 8'hFF;
  localparam int ALT_BIT = 6;
  localparam logic [2:0] SEQ_LAST = 3'h6;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_UNLOCK = 3'h1,
    OP_LOCK = 3'h2,
    OP_SECTOR_ERASE = 3'h3,
    OP_CHIP_ERASE = 3'h4,
    OP_PROGRAM = 3'h5,
    OP_ABORT = 3'h6
  } op_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_s;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } pins_s;

  typedef struct packed {
    logic is_read;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } step_s;

  // Address series of the seven-read write_lock_sequence; the final entry differs for locking.
  function automatic logic [ADDR_W-1:0] lock_seq_addr(input logic [2:0] idx, input logic lock);
    unique case (idx)
      3'h0: return 19'h0_1823;
      3'h1: return 19'h0_1820;
      3'h2: return 19'h0_1822;
      3'h3: return 19'h0_0418;
      3'h4: return 19'h0_041B;
      3'h5: return 19'h0_0419;
      default: return lock ? 19'h0_040A : 19'h0_041A;
    endcase
  endfunction

  // What bus cycle a given step of an operation performs.
  function automatic step_s step_info(input op_e op, input logic [2:0] idx,
                                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    step_s s;
    s = '{is_read: 1'b0, last: 1'b1, addr: a, data: d};
    unique case (op)
      OP_READ: s.is_read = 1'b1;
      OP_UNLOCK, OP_LOCK: begin
        s.is_read = 1'b1;
        s.last = (idx == SEQ_LAST);
        s.addr = lock_seq_addr(idx, op == OP_LOCK);
      end
      OP_SECTOR_ERASE: begin
        s.last = idx[0];
        s.data = idx[0] ? CMD_SECTOR_EXEC : CMD_SECTOR_SETUP;
      end
      OP_CHIP_ERASE: begin
        s.last = idx[0];
        s.data = CMD_CHIP_ERASE;
      end
      OP_PROGRAM: begin
        s.last = idx[0];
        s.data = idx[0] ? d : CMD_PROGRAM_SETUP;
      end
      default: s.data = CMD_ABORT;
    endcase
    return s;
  endfunction

endpackage

// [flash_device_model.sv]
// Behavioural byte-wide flash device that answers the sequencer's pin cycles.
module flash_device_model #(
  parameter int PROG_NS = 35000,
  parameter int SECTOR_NS = 2000000,
  parameter int CHIP_NS = 20000000,
  parameter int SLOW_NS = 8000000,
  parameter logic [7:0] ERASED = 8'hFF
) (
  // Controller pins and a bench knob that makes erases overrun
  input wire flash_seq_pkg::pins_s pins,
  input wire logic stretch,
  // Data pins back to the controller
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [18:0] SEQ [6] = '{19'h0_1823, 19'h0_1820, 19'h0_1822, 19'h0_0418,
                                      19'h0_041B, 19'h0_0419};
  logic [7:0] mem [int];
  logic [18:0] wa = '0;
  logic [7:0] rv = 8'h00;
  logic [7:0] target = 8'h00;
  logic locked = 1'b1;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic wr_act = 1'b0;
  logic rd_act = 1'b0;
  logic rd_on = 1'b0;
  int gen = 0;
  int seq = 0;
  int st = 0;

  // Released pins show the inverse of the last byte, so a stale sample never passes.
  assign dq = rd_on ? rv : ~rv;

  task automatic complete(input int kind, input logic [7:0] d);
    busy = 1'b0;
    tog = 1'b0;
    if (kind == 3) mem[int'(wa)] = d;
    else if (kind == 2) mem.delete();
    else for (int i = 0; i < 256; i++) mem.delete(int'({wa[18:8], 8'(i)}));
  endtask

  task automatic start(input int kind, input int ns, input logic [7:0] d);
    int g;
    gen++;
    g = gen;
    busy = 1'b1;
    target = (kind == 3) ? d : ERASED;
    fork
      begin
        #(ns * 1ns);
        if (gen == g) complete(kind, d);
      end
    join_none
  endtask

  task automatic take(input logic [7:0] d);
    if (locked) return;
    if (busy) begin
      if (d == 8'hFF) begin
        gen++;
        busy = 1'b0;
      end
      return;
    end
    if (st == 1 && d == 8'hD0) start(1, stretch ? SLOW_NS : SECTOR_NS, d);
    else if (st == 2 && d == 8'h30) start(2, stretch ? SLOW_NS : CHIP_NS, d);
    else if (st == 3 && d != 8'hFF) start(3, PROG_NS, d);
    if (st != 0) st = 0;
    else st = (d == 8'h20) ? 1 : (d == 8'h30) ? 2 : (d == 8'h10) ? 3 : 0;
  endtask

  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n && pins.oe_n) begin
      wa = pins.addr;
      wr_act = 1'b1;
    end
  end

  always @(posedge pins.we_n or posedge pins.ce_n) begin
    if (wr_act) begin
      wr_act = 1'b0;
      take(pins.dq_out);
    end
  end

  always @(negedge pins.oe_n) begin
    if (!pins.ce_n && pins.we_n) begin
      rd_act = 1'b1;
      rv = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : ERASED;
      if (busy) begin
        rv[7] = ~target[7];
        rv[6] = tog;
        tog = ~tog;
      end
      rd_on = 1'b1;
    end
  end

  always @(posedge pins.oe_n or posedge pins.ce_n) begin
    if (rd_act) begin
      rd_act = 1'b0;
      rd_on = 1'b0;
      if (seq == 6 && pins.addr == 19'h0_041A) locked = 1'b0;
      if (seq == 6 && pins.addr == 19'h0_040A) locked = 1'b1;
      seq = (seq < 6 && pins.addr == SEQ[seq]) ? seq + 1 : int'(pins.addr == SEQ[0]);
    end
  end
endmodule // flash_device_model

// [flash_erase_program_sequencer_tb.sv]
// Self-checking bench for the flash sequencer against a behavioural device.
module flash_erase_program_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW_CYC = 1200;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  flash_seq_pkg::req_s req = '0;
  logic req_valid = 1'b0;
  logic stretch = 1'b0;
  logic req_ready;
  logic busy;
  logic done;
  logic err;
  logic [7:0] rd_data;
  logic [7:0] dq_in;
  flash_seq_pkg::pins_s pins;
  logic [7:0] exp_mem [int];
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic unlocked = 1'b0;
  logic [18:0] a;
  logic [7:0] d;

  flash_erase_program_sequencer #(.SECTOR_LIMIT_CYC(20'h0_0190), .CHIP_LIMIT_CYC(20'h0_0320)) dut (
    .ref_clk(ref_clk), .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .busy(busy), .done(done), .err(err), .rd_data(rd_data), .pins(pins), .dq_in(dq_in));
  flash_device_model #(.SECTOR_NS(4000), .CHIP_NS(8000), .SLOW_NS(SLOW_CYC * 25)) dev (
    .pins(pins), .stretch(stretch), .dq(dq_in));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A hung handshake ends the run here rather than stalling forever.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_flag(input string what, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic issue(input flash_seq_pkg::op_e op, input logic [18:0] ad, input logic [7:0] dt);
    @(posedge ref_clk);
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    req = '{op: op, addr: ad, data: dt};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
  endtask

  task automatic wait_done(input logic ee);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk_flag("done", 1'b1, done);
    chk_flag("err", ee, err);
    chk_flag("busy", 1'b0, busy);
    chk_flag("req_ready", 1'b1, req_ready);
  endtask

  task automatic prog(input logic [18:0] ad, input logic [7:0] dt);
    issue(flash_seq_pkg::OP_PROGRAM, ad, dt);
    wait_done(1'b0);
    if (unlocked) exp_mem[int'(ad)] = dt;
  endtask

  task automatic erase_sec(input logic [18:0] ad, input logic ee);
    issue(flash_seq_pkg::OP_SECTOR_ERASE, ad, 8'h00);
    wait_done(ee);
    for (int i = 0; i < 256; i++) exp_mem.delete(int'({ad[18:8], 8'(i)}));
  endtask

  task automatic rd(input logic [18:0] ad);
    issue(flash_seq_pkg::OP_READ, ad, 8'h00);
    wait_done(1'b0);
    chk_byte("read", exp_mem.exists(int'(ad)) ? exp_mem[int'(ad)] : 8'hFF, rd_data);
  endtask

  initial begin
    void'($urandom(32'h5f63));
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk_flag("ce_n idle", 1'b1, pins.ce_n);
    chk_flag("we_n idle", 1'b1, pins.we_n);
    a = {11'($urandom), 8'hFF};
    d = 8'($urandom) & 8'h7F;
    prog(a, d);
    rd(a);
    issue(flash_seq_pkg::OP_UNLOCK, 19'h0_0000, 8'h00);
    wait_done(1'b0);
    unlocked = 1'b1;
    for (int i = -1; i < 2; i++) prog(a + 19'(i), d ^ 8'(i + 2));
    for (int i = -1; i < 2; i++) rd(a + 19'(i));
    erase_sec(a, 1'b0);
    for (int i = -1; i < 2; i++) rd(a + 19'(i));
    stretch = 1'b1;
    erase_sec(a + 19'h0_0001, 1'b1);
    @(posedge ref_clk);
    #1;
    chk_flag("err stands", 1'b1, err);
    // A reset between operations must clear the reported status and leave the pins idle.
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk_flag("err after reset", 1'b0, err);
    chk_flag("ready after reset", 1'b1, req_ready);
    chk_flag("busy after reset", 1'b0, busy);
    chk_byte("rd_data after reset", 8'h00, rd_data);
    chk_flag("ce_n after reset", 1'b1, pins.ce_n);
    repeat (SLOW_CYC) @(posedge ref_clk);
    rd(a + 19'h0_0001);
    prog(a + 19'h0_0001, d);
    issue(flash_seq_pkg::OP_SECTOR_ERASE, a + 19'h0_0001, 8'h00);
    repeat (40) @(posedge ref_clk);
    #1;
    req = '{op: flash_seq_pkg::OP_ABORT, addr: a, data: 8'h00};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    wait_done(1'b0);
    rd(a + 19'h0_0001);
    stretch = 1'b0;
    erase_sec(a + 19'h0_0001, 1'b0);
    rd(a + 19'h0_0001);
    for (int i = 0; i < 3; i++) begin
      prog(19'($urandom), 8'($urandom) & 8'h7E);
    end
    prog(a, d);
    issue(flash_seq_pkg::OP_CHIP_ERASE, a, 8'h00);
    wait_done(1'b0);
    exp_mem.delete();
    rd(a);
    issue(flash_seq_pkg::OP_ABORT, a, 8'h00);
    wait_done(1'b0);
    prog(a, d);
    rd(a);
    issue(flash_seq_pkg::OP_LOCK, 19'h0_0000, 8'h00);
    wait_done(1'b0);
    unlocked = 1'b0;
    prog(a - 19'h0_0001, 8'h00);
    rd(a - 19'h0_0001);
    give_verdict();
  end
endmodule // flash_erase_program_sequencer_tb
